// ===== include/iem_pkg.sv
// Types shared by the interrupt enable block
package iem_pkg;

  typedef struct packed {
    logic       command;
    logic       prox_three;
    logic       prox_two;
    logic       prox_one;
    logic [1:0] light;
  } iem_events_t;

  typedef enum logic [8:0] {
    IEM_IDLE   = 9'b000000001,
    IEM_ADDR   = 9'b000000010,
    IEM_ACK_A  = 9'b000000100,
    IEM_PTR    = 9'b000001000,
    IEM_ACK_P  = 9'b000010000,
    IEM_WDATA  = 9'b000100000,
    IEM_ACK_W  = 9'b001000000,
    IEM_RDATA  = 9'b010000000,
    IEM_RACK   = 9'b100000000
  } iem_state_t;

endpackage

// ===== include/iem_regs.svh
// Register offsets, field positions and reset values of the interrupt enable block
`ifndef IEM_REGS_SVH
`define IEM_REGS_SVH

`define IEM_I2C_ADDR          7'h5a
`define IEM_OFS_PIN_CTRL      8'h03
`define IEM_OFS_SRC_ENABLE    8'h04
`define IEM_OFS_PENDING       8'h21

`define IEM_BIT_DRIVE_EN      0
`define IEM_BIT_CLEAR_MODE    1

`define IEM_BIT_LIGHT_LO      0
`define IEM_BIT_LIGHT_HI      1
`define IEM_BIT_PROX_ONE      2
`define IEM_BIT_PROX_TWO      3
`define IEM_BIT_PROX_THREE    4
`define IEM_BIT_COMMAND       5

`define IEM_ENABLE_MASK       8'h3f
`define IEM_PIN_CTRL_MASK     8'h03
`define IEM_RST_SRC_ENABLE    8'h00
`define IEM_RST_PIN_CTRL      8'h00
`define IEM_RST_PENDING       6'h00
`define IEM_READ_UNMAPPED     8'h00

`endif

// ===== testbench/iem_host.sv
// Host controller model on the I2C pins
`timescale 1ns/1ps
module iem_host (
  input  wire logic ref_clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic rel;
  // Pull-up wins when nobody pulls low
  assign sda = rel && !sda_oe;
  initial begin
    scl = 1'b1;
    rel = 1'b1;
  end
  task automatic tw();
    repeat (5) @(negedge ref_clk);
  endtask
  task automatic bit_x(input logic b, output logic r);
    rel = b;
    tw();
    scl = 1'b1;
    tw();
    r = sda;
    tw();
    scl = 1'b0;
    tw();
  endtask
  task automatic start();
    rel = 1'b1;
    tw();
    scl = 1'b1;
    tw();
    rel = 1'b0;
    tw();
    scl = 1'b0;
    tw();
  endtask
  task automatic stop();
    rel = 1'b0;
    tw();
    scl = 1'b1;
    tw();
    rel = 1'b1;
    tw();
  endtask
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic wr(input logic [7:0] sa, input logic [7:0] a, input logic [7:0] d,
                    output logic ok);
    logic k1, k2, k3;
    start();
    wb(sa, k1);
    wb(a, k2);
    wb(d, k3);
    stop();
    ok = k1 && k2 && k3;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start();
    wb(8'hb4, k);
    wb(a, k);
    start();
    wb(8'hb5, k);
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(1'b1, k);
    stop();
  endtask
endmodule

// ===== testbench/iem_int_enable_checker.sv
// Port assertions for the interrupt enable block
`timescale 1ns/1ps
module iem_checker (
  input wire logic                 ref_clk,
  input wire logic                 reset_n,
  input wire logic                 scl_in,
  input wire logic                 sda_in,
  input wire logic                 sda_out,
  input wire logic                 sda_oe,
  input wire logic                 int_out,
  input wire logic                 int_oe,
  input wire iem_pkg::iem_events_t event_set
);
  import iem_pkg::*;
  logic [5:0] quiet_reg;
  logic       scl_d_reg;
  logic       touched_reg;
  // Cycles since the bus clock last moved
  always_ff @(posedge ref_clk) begin
    scl_d_reg <= scl_in;
    if (!reset_n || scl_in != scl_d_reg) begin
      quiet_reg <= 6'h00;
    end else if (quiet_reg != 6'h3f) begin
      quiet_reg <= quiet_reg + 6'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    touched_reg <= reset_n && (touched_reg || !scl_in);
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  AST_OUT_ZERO: assert property (!sda_out && !int_out)
    else $error("open drain output value not zero");
  AST_RST_REL: assert property ($rose(reset_n) |-> !int_oe && !sda_oe)
    else $error("pins driven right after reset");
  AST_UNTOUCHED: assert property (!touched_reg |-> !int_oe)
    else $error("interrupt before any host access");
  AST_RISE_CAUSE: assert property (
    $rose(int_oe) |-> $past(event_set, 2) != '0 || quiet_reg < 6'h0a)
    else $error("interrupt rose without cause");
  AST_STICKY: assert property (int_oe && quiet_reg >= 6'h0a |=> int_oe)
    else $error("interrupt dropped without host clear");
  AST_FALL_CAUSE: assert property ($fell(int_oe) |-> quiet_reg < 6'h0a)
    else $error("interrupt fell outside a bus write");
  AST_SDA_LOW_PHASE: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line changed while bus clock high");
  AST_IDLE_FREE: assert property (quiet_reg == 6'h3f |-> !sda_oe)
    else $error("data line held on idle bus");
endmodule

bind iem_int_enable iem_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe),
  .event_set(event_set));

// ===== testbench/tb.sv
// Self-checking bench for the interrupt enable block
`timescale 1ns/1ps
`include "iem_regs.svh"
module tb;
  import iem_pkg::*;
  logic        ref_clk;
  logic        reset_n;
  logic        scl;
  logic        sda;
  logic        sda_out;
  logic        sda_oe;
  logic        int_out;
  logic        int_oe;
  iem_events_t event_set;
  logic [7:0]  rdv;
  logic        ok;
  int          fail_count;
  int          n_checks;
  iem_int_enable DUT (.ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe),
    .event_set(event_set));
  iem_host host (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic rst();
    reset_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    host.wr(8'hb4, a, d, ok);
    chk({7'h00, ok}, 8'h01);
  endtask
  task automatic creg(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rdv);
    chk(rdv, e);
  endtask
  // Event pulse, then pin level two edges later
  task automatic pulse(input logic [5:0] m, input logic e);
    event_set = m;
    @(negedge ref_clk);
    event_set = '0;
    repeat (2) @(negedge ref_clk);
    chk({7'h00, int_oe}, {7'h00, e});
  endtask
  initial begin
    fail_count = 0;
    n_checks = 0;
    event_set = '0;
    rst();
    creg(`IEM_OFS_SRC_ENABLE, 8'h00);
    creg(`IEM_OFS_PENDING, 8'h00);
    wreg(`IEM_OFS_PIN_CTRL, 8'h01);
    pulse(6'h3f, 1'b0);
    creg(`IEM_OFS_PENDING, 8'h3f);
    wreg(`IEM_OFS_PENDING, 8'h3f);
    for (int k = 0; k < 6; k++) begin
      wreg(`IEM_OFS_SRC_ENABLE, 8'h01 << k);
      pulse(6'h3f & ~(6'h01 << k), 1'b0);
      pulse(6'h01 << k, 1'b1);
      repeat (40) @(negedge ref_clk);
      chk({7'h00, int_oe}, 8'h01);
      wreg(`IEM_OFS_PENDING, 8'h3f);
      chk({7'h00, int_oe}, 8'h00);
    end
    wreg(`IEM_OFS_SRC_ENABLE, 8'hff);
    creg(`IEM_OFS_SRC_ENABLE, 8'h3f);
    wreg(`IEM_OFS_PIN_CTRL, 8'h00);
    pulse(6'h3f, 1'b0);
    wreg(`IEM_OFS_PIN_CTRL, 8'h01);
    chk({7'h00, int_oe}, 8'h01);
    wreg(`IEM_OFS_PIN_CTRL, 8'hff);
    creg(`IEM_OFS_PIN_CTRL, 8'h03);
    chk({7'h00, int_oe}, 8'h01);
    wreg(`IEM_OFS_SRC_ENABLE, 8'hc0);
    chk({7'h00, int_oe}, 8'h00);
    host.wr(8'hb6, `IEM_OFS_SRC_ENABLE, 8'h3f, ok);
    chk({7'h00, ok}, 8'h00);
    creg(`IEM_OFS_SRC_ENABLE, 8'h00);
    creg(8'h10, `IEM_READ_UNMAPPED);
    wreg(`IEM_OFS_SRC_ENABLE, 8'h3f);
    rst();
    chk({7'h00, int_oe}, 8'h00);
    creg(`IEM_OFS_SRC_ENABLE, 8'h00);
    chk({6'h00, sda_out, int_out}, 8'h00);
    summarize();
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    summarize();
  end
endmodule

// ===== verilog/iem_int_enable.sv
// Interrupt source enable mask with I2C register access and open-drain interrupt pin
// Behaviour
// - Enable register resets to all zeros
// - Bit 5 gates command event onto pin
// - Bit 4 gates third proximity event
// - Bit 3 gates second proximity event
// - Bit 2 gates first proximity event
// - Bits 1:0 gate each light event bit
// - Drive enable set: pin low on match
// - Pending flags sticky until host clears them
`timescale 1ns/1ps
`include "iem_regs.svh"
module iem_int_enable (
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  output logic                     int_out,
  output logic                     int_oe,
  input  wire iem_pkg::iem_events_t event_set
);
  import iem_pkg::*;

  logic [1:0]   pins_sync;
  logic         scl_d_reg;
  logic         sda_d_reg;
  logic         scl_s;
  logic         sda_s;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_seen;
  logic         stop_seen;
  iem_state_t   state_reg;
  logic [3:0]   bit_cnt_reg;
  logic [7:0]   shift_reg;
  logic [7:0]   tx_reg;
  logic [7:0]   ptr_reg;
  logic         read_mode_reg;
  logic         nack_reg;
  logic         wr_strobe;
  logic [7:0]   source_enable_reg;
  logic [7:0]   pin_ctrl_reg;
  logic [5:0]   pending_reg;
  logic [5:0]   pending_next;
  logic [5:0]   pending_clear;
  logic         int_drive_next;
  logic [7:0]   rd_byte;

  iem_sync #(
    .WIDTH (2)
  ) u_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .async_in ({scl_in, sda_in}),
    .sync_out (pins_sync)
  );

  assign scl_s      = pins_sync[1];
  assign sda_s      = pins_sync[0];
  assign scl_rise   = scl_s & ~scl_d_reg;
  assign scl_fall   = ~scl_s & scl_d_reg;
  assign start_seen = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_seen  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // Register read decode
  function automatic logic [7:0] read_byte(input logic [7:0] ofs,
                                           input logic [7:0] en,
                                           input logic [7:0] ctrl,
                                           input logic [5:0] pend);
    if (ofs == `IEM_OFS_SRC_ENABLE) begin
      read_byte = en & `IEM_ENABLE_MASK;
    end else if (ofs == `IEM_OFS_PIN_CTRL) begin
      read_byte = ctrl & `IEM_PIN_CTRL_MASK;
    end else if (ofs == `IEM_OFS_PENDING) begin
      read_byte = {2'h0, pend};
    end else begin
      read_byte = `IEM_READ_UNMAPPED;
    end
  endfunction

  // Byte the pointer selects, loaded at each read byte start
  assign rd_byte = read_byte(ptr_reg, source_enable_reg, pin_ctrl_reg, pending_reg);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // Write strobe: a data byte fully received on the falling edge after bit 8
  assign wr_strobe = (state_reg == IEM_WDATA) && scl_fall && (bit_cnt_reg == 4'h8);

  // I2C slave sequencing
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg     <= IEM_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      tx_reg        <= 8'h00;
      ptr_reg       <= 8'h00;
      read_mode_reg <= 1'b0;
      nack_reg      <= 1'b0;
      sda_oe        <= 1'b0;
    end else if (start_seen) begin
      state_reg   <= IEM_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe      <= 1'b0;
    end else if (stop_seen) begin
      state_reg <= IEM_IDLE;
      sda_oe    <= 1'b0;
    end else if (scl_rise) begin
      if (state_reg == IEM_RACK) begin
        nack_reg <= sda_s;
      end else if (state_reg == IEM_ADDR || state_reg == IEM_PTR ||
                   state_reg == IEM_WDATA || state_reg == IEM_RDATA) begin
        shift_reg   <= {shift_reg[6:0], sda_s};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end else if (scl_fall) begin
      case (state_reg)
        IEM_ADDR: begin
          if (bit_cnt_reg == 4'h8) begin
            if (shift_reg[7:1] == `IEM_I2C_ADDR) begin
              read_mode_reg <= shift_reg[0];
              sda_oe        <= 1'b1;
              state_reg     <= IEM_ACK_A;
            end else begin
              state_reg <= IEM_IDLE;
            end
          end
        end
        IEM_ACK_A: begin
          bit_cnt_reg <= 4'h0;
          if (read_mode_reg) begin
            tx_reg    <= rd_byte;
            ptr_reg   <= ptr_reg + 8'h01;
            sda_oe    <= ~rd_byte[7];
            state_reg <= IEM_RDATA;
          end else begin
            sda_oe    <= 1'b0;
            state_reg <= IEM_PTR;
          end
        end
        IEM_PTR: begin
          if (bit_cnt_reg == 4'h8) begin
            ptr_reg   <= shift_reg;
            sda_oe    <= 1'b1;
            state_reg <= IEM_ACK_P;
          end
        end
        IEM_ACK_P, IEM_ACK_W: begin
          sda_oe      <= 1'b0;
          bit_cnt_reg <= 4'h0;
          state_reg   <= IEM_WDATA;
        end
        IEM_WDATA: begin
          if (bit_cnt_reg == 4'h8) begin
            ptr_reg   <= ptr_reg + 8'h01;
            sda_oe    <= 1'b1;
            state_reg <= IEM_ACK_W;
          end
        end
        IEM_RDATA: begin
          if (bit_cnt_reg == 4'h8) begin
            sda_oe    <= 1'b0;
            state_reg <= IEM_RACK;
          end else begin
            sda_oe <= ~tx_reg[3'h7 - bit_cnt_reg[2:0]];
          end
        end
        IEM_RACK: begin
          bit_cnt_reg <= 4'h0;
          if (nack_reg) begin
            sda_oe    <= 1'b0;
            state_reg <= IEM_IDLE;
          end else begin
            tx_reg    <= rd_byte;
            ptr_reg   <= ptr_reg + 8'h01;
            sda_oe    <= ~rd_byte[7];
            state_reg <= IEM_RDATA;
          end
        end
        default: begin
          state_reg <= IEM_IDLE;
          sda_oe    <= 1'b0;
        end
      endcase
    end
  end

  // Source enable register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      source_enable_reg <= `IEM_RST_SRC_ENABLE;
    end else if (wr_strobe && ptr_reg == `IEM_OFS_SRC_ENABLE) begin
      source_enable_reg <= shift_reg & `IEM_ENABLE_MASK;
    end
  end

  // Pin drive enable and clear mode
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pin_ctrl_reg <= `IEM_RST_PIN_CTRL;
    end else if (wr_strobe && ptr_reg == `IEM_OFS_PIN_CTRL) begin
      pin_ctrl_reg <= shift_reg & `IEM_PIN_CTRL_MASK;
    end
  end

  // Sticky pending flags, write one to clear, a new event wins
  always_comb begin
    pending_clear = 6'h00;
    if (wr_strobe && ptr_reg == `IEM_OFS_PENDING) begin
      pending_clear = shift_reg[5:0];
    end
    pending_next = (pending_reg & ~pending_clear) | event_set;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pending_reg <= `IEM_RST_PENDING;
    end else begin
      pending_reg <= pending_next;
    end
  end

  // Interrupt pin: drive low when any enabled source is pending and drive enable is set
  always_comb begin
    int_drive_next = 1'b0;
    if (pending_reg[`IEM_BIT_COMMAND] && source_enable_reg[`IEM_BIT_COMMAND]) begin
      int_drive_next = 1'b1;
    end
    if (pending_reg[`IEM_BIT_PROX_THREE] && source_enable_reg[`IEM_BIT_PROX_THREE]) begin
      int_drive_next = 1'b1;
    end
    if (pending_reg[`IEM_BIT_PROX_TWO] && source_enable_reg[`IEM_BIT_PROX_TWO]) begin
      int_drive_next = 1'b1;
    end
    if (pending_reg[`IEM_BIT_PROX_ONE] && source_enable_reg[`IEM_BIT_PROX_ONE]) begin
      int_drive_next = 1'b1;
    end
    if (|(pending_reg[`IEM_BIT_LIGHT_HI:`IEM_BIT_LIGHT_LO] &
          source_enable_reg[`IEM_BIT_LIGHT_HI:`IEM_BIT_LIGHT_LO])) begin
      int_drive_next = 1'b1;
    end
    if (!pin_ctrl_reg[`IEM_BIT_DRIVE_EN]) begin
      int_drive_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      int_oe  <= 1'b0;
      int_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      int_oe  <= int_drive_next;
      int_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end
endmodule

// ===== verilog/iem_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module iem_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_reg;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stage_reg <= '1;
      sync_out  <= '1;
    end else begin
      stage_reg <= async_in;
      sync_out  <= stage_reg;
    end
  end
endmodule
